// >>> verilog/intc_top.sv
// priority interrupt controller with trap and reset source handling
`timescale 1ns/1ps
module intc_top
(
    // clock and reset
    input  wire logic                                  MCLK_IN,
    input  wire logic                                  RST_IN,
    // instruction cycle strobe from the core
    input  wire logic                                  INSTR_START_IN,
    // peripheral events and flag clear
    input  wire logic [intc_pkg::NUM_SRC-1:0]          EVENT_IN,
    input  wire logic [intc_pkg::NUM_SRC-1:0]          FLAG_CLEAR_IN,
    // enables and priorities
    input  wire logic [intc_pkg::NUM_SRC-1:0]          ENABLE_WR_IN,
    input  wire logic                                  ENABLE_WE_IN,
    input  wire logic [intc_pkg::NUM_SRC*4-1:0]        PRIO_WR_IN,
    input  wire logic                                  PRIO_WE_IN,
    // cpu priority level and controls
    input  wire logic [intc_pkg::IPL_W-1:0]            IPL_WR_IN,
    input  wire logic                                  IPL_WE_IN,
    input  wire logic                                  NEST_DIS_IN,
    input  wire logic                                  ALT_SEL_IN,
    input  wire logic                                  LOW_PRIORITY_MASK_ACTIVE_START_IN,
    input  wire logic [intc_pkg::LOW_PRIORITY_MASK_ACTIVE_W-1:0]           LOW_PRIORITY_MASK_ACTIVE_COUNT_IN,
    // core handshakes
    input  wire logic                                  ACK_IN,
    input  wire logic                                  RETURN_IN,
    input  wire logic [7:0]                            RESTORE_SRL_IN,
    input  wire logic                                  RESTORE_IPL3_IN,
    // trap and reset causes
    input  wire logic [intc_pkg::NUM_TRAP-1:0]         TRAP_IN,
    input  wire logic                                  TRAP_DONE_IN,
    input  wire logic [intc_pkg::ADDR_W-1:0]           FETCH_ADDR_IN,
    input  wire logic                                  FETCH_IN,
    input  wire logic                                  VECTOR_FETCH_IN,
    input  wire logic                                  JUMP_IN,
    input  wire logic [intc_pkg::ADDR_W-1:0]           JUMP_ADDR_IN,
    input  wire logic                                  UNINIT_PTR_IN,
    input  wire logic                                  ILLEGAL_EXEC_IN,
    input  wire logic                                  FLUSH_IN,
    input  wire logic                                  WDT_TIMEOUT_IN,
    // status back to software
    output logic [intc_pkg::NUM_SRC-1:0]               FLAGS_OUT,
    output logic [intc_pkg::NUM_SRC-1:0]               ENABLES_OUT,
    output logic [intc_pkg::NUM_SRC*4-1:0]             PRIOS_OUT,
    output logic [intc_pkg::IPL_W-1:0]                 IPL_OUT,
    output logic                                       LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT,
    // request to core
    output logic                                       IRQ_OUT,
    output logic [intc_pkg::VEC_W-1:0]                 VECTOR_OUT,
    output logic [intc_pkg::ADDR_W-1:0]                VEC_ADDR_OUT,
    output logic [7:0]                                 PUSH_SRL_OUT,
    output logic                                       ADDR_ERR_OUT,
    output logic                                       DEV_RESET_OUT
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_REQ   = 3'b010,
        ST_SERV  = 3'b100
    } phase_e;

    typedef struct packed
    {
        phase_e                               phase;
        logic [intc_pkg::NUM_SRC-1:0]         flag;
        logic [intc_pkg::NUM_SRC-1:0]         en;
        logic [intc_pkg::NUM_SRC*3-1:0]       prio;
        logic [intc_pkg::IPL_W-1:0]           cpu_priority_level;
        logic [intc_pkg::LOW_PRIORITY_MASK_ACTIVE_W-1:0]          low_priority_mask_active_cnt;
        logic                                 low_priority_mask_active;
        logic [2:0]                           serv_depth;
        logic                                 irq;
        logic [intc_pkg::VEC_W-1:0]           vec;
        logic [intc_pkg::ADDR_W-1:0]          vaddr;
        logic [7:0]                           status_low_byte;
        logic                                 addr_err;
        logic                                 dev_rst;
        logic [2:0]                           pend_lvl;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic                           win_found;
    logic [intc_pkg::NUM_W-1:0]     win_num;
    logic [intc_pkg::PRIO_W-1:0]    win_lvl;
    logic [intc_pkg::NUM_SRC-1:0]   active_req;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic in_vec_space(input logic [intc_pkg::ADDR_W-1:0] a);
        in_vec_space = (a >= intc_pkg::IVT_BASE) && (a <= intc_pkg::IVT_LAST);
    endfunction : in_vec_space

    // three bits so that all four traps at once cannot wrap to zero
    function automatic logic [2:0] count_traps(input logic [intc_pkg::NUM_TRAP-1:0] t);
        count_traps = 3'(t[0]) + 3'(t[1]) + 3'(t[2]) + 3'(t[3]);
    endfunction : count_traps

    assign active_req = state_reg.flag & state_reg.en & intc_pkg::SRC_PRESENT;

    intc_arbiter u_arb
    (
        .req_in    (active_req),
        .prio_in   (state_reg.prio),
        .found_out (win_found),
        .num_out   (win_num),
        .level_out (win_lvl)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic take_ok;
        logic [intc_pkg::VEC_W-1:0] vnum;
        take_ok    = 1'b0;
        vnum       = '0;
        state_next = state_reg;
        state_next.addr_err = 1'b0;
        state_next.dev_rst  = 1'b0;

        // set wins over clear
        state_next.flag = ((state_reg.flag & ~FLAG_CLEAR_IN) | EVENT_IN)
                          & intc_pkg::SRC_PRESENT;
        if (ENABLE_WE_IN)
            state_next.en = ENABLE_WR_IN & intc_pkg::SRC_PRESENT;
        if (PRIO_WE_IN)
        begin
            for (int i = 0; i < intc_pkg::NUM_SRC; i++)
            begin
                state_next.prio[i*3 +: 3] = intc_pkg::SRC_PRESENT[i] ?
                                            PRIO_WR_IN[i*4 +: 3] : 3'h0;
            end
        end
        if (IPL_WE_IN && !NEST_DIS_IN)
            state_next.cpu_priority_level = {state_reg.cpu_priority_level[3], IPL_WR_IN[2:0]};

        // low-priority masking countdown
        if (LOW_PRIORITY_MASK_ACTIVE_START_IN && LOW_PRIORITY_MASK_ACTIVE_COUNT_IN != '0)
        begin
            state_next.low_priority_mask_active_cnt = LOW_PRIORITY_MASK_ACTIVE_COUNT_IN;
            state_next.low_priority_mask_active     = 1'b1;
        end
        else if (INSTR_START_IN && state_reg.low_priority_mask_active)
        begin
            state_next.low_priority_mask_active_cnt = state_reg.low_priority_mask_active_cnt - 14'h0001;
            state_next.low_priority_mask_active     = (state_reg.low_priority_mask_active_cnt != 14'h0001);
        end

        // several traps at once force a device reset
        if (count_traps(TRAP_IN) > 3'h1)
            state_next.dev_rst = 1'b1;

        if (UNINIT_PTR_IN || (ILLEGAL_EXEC_IN && !FLUSH_IN) || WDT_TIMEOUT_IN)
            state_next.dev_rst = 1'b1;

        if ((FETCH_IN && !VECTOR_FETCH_IN && in_vec_space(FETCH_ADDR_IN)) ||
            (JUMP_IN && in_vec_space(JUMP_ADDR_IN)))
            state_next.addr_err = 1'b1;

        // strictly above level; msb set means a trap holds the core
        take_ok = win_found && !state_reg.cpu_priority_level[3] &&
                  ({1'b0, win_lvl} > state_reg.cpu_priority_level) &&
                  !(state_reg.low_priority_mask_active && win_lvl <= intc_pkg::LOW_PRIORITY_MASK_ACTIVE_BLOCK_MAX) &&
                  !(NEST_DIS_IN && state_reg.serv_depth != 3'h0);
        vnum = 7'(win_num) + 7'(intc_pkg::VEC_OFFSET);

        case (state_reg.phase)
            ST_IDLE:
            begin
                if (INSTR_START_IN && take_ok)
                begin
                    state_next.phase    = ST_REQ;
                    state_next.irq      = 1'b1;
                    state_next.vec      = vnum;
                    state_next.pend_lvl = win_lvl;
                    // each vector is one two-byte word entry
                    state_next.vaddr = (ALT_SEL_IN ? intc_pkg::ALTERNATE_VECTOR_TABLE_BASE : intc_pkg::IVT_BASE)
                                       + {16'h0000, vnum, 1'b0};
                    state_next.status_low_byte   = {5'h00, state_reg.cpu_priority_level[2:0]};
                end
            end
            ST_REQ:
            begin
                if (ACK_IN)
                begin
                    state_next.phase      = ST_SERV;
                    state_next.irq        = 1'b0;
                    state_next.cpu_priority_level        = {1'b0, state_reg.pend_lvl};
                    state_next.serv_depth = state_reg.serv_depth + 3'h1;
                end
            end
            ST_SERV:
            begin
                state_next.phase = ST_IDLE;
            end
            default:
            begin
                state_next.phase = ST_IDLE;
            end
        endcase

        if (RETURN_IN && state_reg.serv_depth != 3'h0)
        begin
            state_next.serv_depth = state_next.serv_depth - 3'h1;
            state_next.cpu_priority_level        = {RESTORE_IPL3_IN, RESTORE_SRL_IN[2:0]};
        end

        // trap msb applied last: a coincident acknowledge or return must not drop it
        if (count_traps(TRAP_IN) == 3'h1)
            state_next.cpu_priority_level[3] = 1'b1;
        else if (TRAP_DONE_IN)
            state_next.cpu_priority_level[3] = 1'b0;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            // reset is handled here directly, never as a vectored request
            state_reg.phase      <= ST_IDLE;
            state_reg.flag       <= intc_pkg::SRC_RESET;
            state_reg.en         <= intc_pkg::SRC_RESET;
            state_reg.prio       <= {intc_pkg::NUM_SRC{intc_pkg::PRIO_RESET}}
                                    & {intc_pkg::NUM_SRC{3'h7}};
            state_reg.cpu_priority_level        <= intc_pkg::IPL_RESET;
            state_reg.low_priority_mask_active_cnt   <= '0;
            state_reg.low_priority_mask_active       <= 1'b0;
            state_reg.serv_depth <= 3'h0;
            state_reg.irq        <= 1'b0;
            state_reg.vec        <= '0;
            state_reg.vaddr      <= intc_pkg::RESET_PC;
            state_reg.status_low_byte        <= 8'h00;
            state_reg.addr_err   <= 1'b0;
            state_reg.dev_rst    <= 1'b0;
            state_reg.pend_lvl   <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb
    begin
        FLAGS_OUT       = state_reg.flag;
        ENABLES_OUT     = state_reg.en;
        for (int i = 0; i < intc_pkg::NUM_SRC; i++)
        begin
            // reserved fields read zero although reset loads every field
            PRIOS_OUT[i*4 +: 4] = intc_pkg::SRC_PRESENT[i] ?
                                  {1'b0, state_reg.prio[i*3 +: 3]} : 4'h0;
        end
        IPL_OUT         = state_reg.cpu_priority_level;
        LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT = state_reg.low_priority_mask_active;
        IRQ_OUT         = state_reg.irq;
        VECTOR_OUT      = state_reg.vec;
        VEC_ADDR_OUT    = state_reg.vaddr;
        PUSH_SRL_OUT    = state_reg.status_low_byte;
        ADDR_ERR_OUT    = state_reg.addr_err;
        DEV_RESET_OUT   = state_reg.dev_rst;
    end
endmodule : intc_top

// >>> verilog/intc_pkg.sv
// shared constants for the priority interrupt controller
package intc_pkg;
    localparam int NUM_SRC       = 54;
    localparam int NUM_TRAP      = 4;
    localparam int NUM_USED      = 29;
    localparam int PRIO_W        = 3;
    localparam int IPL_W         = 4;
    localparam int NUM_W         = 6;
    localparam int VEC_W         = 7;
    localparam int ADDR_W        = 24;
    localparam int LOW_PRIORITY_MASK_ACTIVE_W        = 14;
    localparam logic [NUM_W-1:0] VEC_OFFSET     = 6'h08;
    localparam logic [2:0]       LOW_PRIORITY_MASK_ACTIVE_BLOCK_MAX = 3'h6;
    localparam logic [ADDR_W-1:0] RESET_PC      = 24'h00_0000;
    localparam logic [ADDR_W-1:0] IVT_BASE      = 24'h00_0004;
    localparam logic [ADDR_W-1:0] IVT_LAST      = 24'h00_00FE;
    localparam logic [ADDR_W-1:0] ALTERNATE_VECTOR_TABLE_BASE     = 24'h00_0084;
    localparam logic [ADDR_W-1:0] ALTERNATE_VECTOR_TABLE_LAST     = 24'h00_00FE;
    localparam int NESTING_DISABLE_BIT    = 15;
    localparam int LOW_PRIORITY_MASK_ACTIVE_STAT_BIT = 14;
    localparam int ALT_SEL_BIT   = 15;
    // reserved numbers 26-38, 41, 42, 44-53 carry no source
    localparam logic [NUM_SRC-1:0] SRC_PRESENT = 54'h00_0980_03FF_FFFF;
    localparam logic [NUM_SRC-1:0] SRC_RESET   = 54'h00_0000_0000_0000;
    localparam logic [IPL_W-1:0]   IPL_RESET   = 4'h0;
    localparam logic [PRIO_W-1:0]  PRIO_RESET  = 3'h4;
endpackage : intc_pkg

// >>> verilog/intc_arbiter.sv
// combinational winner search over all pending sources
`timescale 1ns/1ps
module intc_arbiter
(
    // request side
    input  wire logic [intc_pkg::NUM_SRC-1:0]          req_in,
    input  wire logic [intc_pkg::NUM_SRC*3-1:0]        prio_in,
    // winner
    output logic                                       found_out,
    output logic [intc_pkg::NUM_W-1:0]                 num_out,
    output logic [intc_pkg::PRIO_W-1:0]                level_out
);
    always_comb
    begin
        found_out = 1'b0;
        num_out   = '0;
        level_out = '0;
        // scan from lowest natural order so lower numbers overwrite on ties
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (req_in[i] && prio_in[i*3 +: 3] != 3'h0 &&
                (!found_out || prio_in[i*3 +: 3] >= level_out))
            begin
                found_out = 1'b1;
                num_out   = 6'(i);
                level_out = prio_in[i*3 +: 3];
            end
        end
    end
endmodule : intc_arbiter

// >>> bench/intc_monitor.sv
// checker for the priority interrupt controller ports
`timescale 1ns/1ps
module intc_monitor
(
    // clock, reset and causes
    input wire logic         MCLK_IN, RST_IN, ACK_IN, ALT_SEL_IN, NEST_DIS_IN, IPL_WE_IN,
    input wire logic         RETURN_IN, TRAP_DONE_IN, LOW_PRIORITY_MASK_ACTIVE_START_IN, FETCH_IN,
    input wire logic         VECTOR_FETCH_IN, WDT_TIMEOUT_IN, UNINIT_PTR_IN,
    input wire logic         ILLEGAL_EXEC_IN, FLUSH_IN,
    input wire logic [53:0]  EVENT_IN,
    input wire logic [3:0]   TRAP_IN,
    input wire logic [13:0]  LOW_PRIORITY_MASK_ACTIVE_COUNT_IN,
    input wire logic [23:0]  FETCH_ADDR_IN,
    // observed outputs
    input wire logic [53:0]  FLAGS_OUT, ENABLES_OUT,
    input wire logic [215:0] PRIOS_OUT,
    input wire logic [3:0]   IPL_OUT,
    input wire logic [6:0]   VECTOR_OUT,
    input wire logic [23:0]  VEC_ADDR_OUT,
    input wire logic         IRQ_OUT, LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT, ADDR_ERR_OUT, DEV_RESET_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    flag_set_a: assert property (EVENT_IN[0] |=> FLAGS_OUT[0])
        else $error("flag not set by event");
    reserved_zero_a: assert property (((FLAGS_OUT | ENABLES_OUT) & ~intc_pkg::SRC_PRESENT) == '0)
        else $error("reserved position reads set");
    nibble_top_a: assert property ((PRIOS_OUT & {54{4'h8}}) == '0)
        else $error("priority nibble top bit set");
    vec_range_a: assert property (IRQ_OUT |-> VECTOR_OUT >= 7'h08 && VECTOR_OUT <= 7'h3D)
        else $error("vector out of range");
    vec_addr_a: assert property (
        IRQ_OUT |-> VEC_ADDR_OUT ==
        (ALT_SEL_IN ? intc_pkg::ALTERNATE_VECTOR_TABLE_BASE : intc_pkg::IVT_BASE) + {VECTOR_OUT, 1'b0})
        else $error("vector address wrong");
    irq_hold_a: assert property (IRQ_OUT && !ACK_IN |=> IRQ_OUT && $stable(VECTOR_OUT))
        else $error("request dropped before acknowledge");
    ack_level_a: assert property (IRQ_OUT && ACK_IN |=> !IRQ_OUT && IPL_OUT > $past(IPL_OUT))
        else $error("level not raised on acknowledge");
    reset_src_a: assert property (
        WDT_TIMEOUT_IN || UNINIT_PTR_IN || $countones(TRAP_IN) > 1
        || (ILLEGAL_EXEC_IN && !FLUSH_IN) |=> DEV_RESET_OUT)
        else $error("reset cause without device reset");
    addr_err_a: assert property (
        FETCH_IN && !VECTOR_FETCH_IN && FETCH_ADDR_IN inside
        {[intc_pkg::IVT_BASE:intc_pkg::IVT_LAST]} |=> ADDR_ERR_OUT)
        else $error("vector space fetch not trapped");
    ipl_ro_a: assert property (
        NEST_DIS_IN && IPL_WE_IN && !IRQ_OUT && !RETURN_IN && !TRAP_DONE_IN
        && TRAP_IN == '0 |=> IPL_OUT == $past(IPL_OUT))
        else $error("level written while nesting disabled");
    trap_ipl_a: assert property ($countones(TRAP_IN) == 1 |=> IPL_OUT[3])
        else $error("trap did not set level msb");
    low_priority_mask_active_on_a: assert property (LOW_PRIORITY_MASK_ACTIVE_START_IN && LOW_PRIORITY_MASK_ACTIVE_COUNT_IN != '0 |=> LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT)
        else $error("masking status not set");
    cover property (IRQ_OUT && ACK_IN);
    cover property (LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT && IRQ_OUT);
    cover property (DEV_RESET_OUT);
endmodule : intc_monitor

bind intc_top intc_monitor u_mon (.*);

// >>> bench/core_model.sv
// core stand-in: instruction strobe, acknowledge, flag clear, return
`timescale 1ns/1ps
module core_model
(
    input  wire logic        clk_in, rst_in, irq_in,
    input  wire logic [6:0]  vec_in,
    input  wire logic [7:0]  push_srl_in,
    input  wire logic [3:0]  ack_wait_in,
    output logic             start_out, ack_out, ret_out,
    output logic [7:0]       srl_out,
    output logic [53:0]      clr_out
);
    int         ph = 0;
    int         w = 0;
    int         d = 0;
    // one handler timer and one saved status byte per nesting level
    int         s [8];
    logic [7:0] sv [8];
    initial {start_out, ack_out, ret_out, srl_out, clr_out} = '0;
    always @(posedge clk_in)
    begin
        #1;
        {start_out, ack_out, ret_out, clr_out} = '0;
        ph = rst_in ? 0 : (ph + 1) % 4;
        start_out = !rst_in && ph == 0;
        if (rst_in)
            d = 0;
        else if (irq_in)
        begin
            w++;
            if (w > int'(ack_wait_in) && d < 7)
            begin
                ack_out = 1'b1;
                clr_out[vec_in - 7'h08] = 1'b1;
                w = 0;
                d++;
                s[d] = 12;
                sv[d] = push_srl_in;
            end
        end
        else if (d > 0)
        begin
            s[d]--;
            if (s[d] == 0)
            begin
                ret_out = 1'b1;
                srl_out = sv[d];
                d--;
            end
        end
    end
endmodule : core_model

// >>> bench/tb.sv
// self-checking testbench for the priority interrupt controller
`timescale 1ns/1ps
module tb;
    localparam logic [23:0] IB = intc_pkg::IVT_BASE;
    logic         clk = 1'b0, rst = 1'b1, enwe = 1'b0, prwe = 1'b0, iplwe = 1'b0, nest = 1'b0;
    logic         alt = 1'b0, dstart = 1'b0, tdone = 1'b0;
    logic [53:0]  ev = '0, tclr = '0, en = '0, mclr, flags, enables;
    logic [215:0] pr = '0, prios;
    logic [3:0]   iplwr = '0, ackw = '0, cpu_priority_level;
    logic [13:0]  dcnt = '0;
    logic [10:0]  ctl = '0;
    logic [23:0]  ad = '0, vaddr;
    logic [6:0]   vec;
    logic [7:0]   psrl, rsrl;
    logic         start, ack, ret, low_priority_mask_active, irq, aerr, dres;
    int           err_total = 0, num_checks = 0, cyc = 0;
    // fetch,vfetch,jump,uninit,illegal,flush,wdt,trap[3:0]
    logic [10:0] ct [12] = '{11'h400, 11'h400, 11'h400, 11'h600, 11'h100, 11'h080, 11'h040,
                             11'h060, 11'h010, 11'h005, 11'h00F, 11'h002};
    logic [23:0] ca [12] = '{24'h00_0004, 24'h00_00FE, 24'h00_0100, 24'h00_0010, 24'h00_0020,
                             24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000,
                             24'h00_0000, 24'h00_0000};
    logic [1:0]  ce [12] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1,
                             2'h0};
    always #25 clk = ~clk;
    core_model u_core (.clk_in(clk), .rst_in(rst), .irq_in(irq), .vec_in(vec), .push_srl_in(psrl),
        .ack_wait_in(ackw), .start_out(start), .ack_out(ack), .ret_out(ret), .srl_out(rsrl),
        .clr_out(mclr));
    intc_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .INSTR_START_IN(start), .EVENT_IN(ev),
        .FLAG_CLEAR_IN(mclr | tclr), .ENABLE_WR_IN(en), .ENABLE_WE_IN(enwe), .PRIO_WR_IN(pr),
        .PRIO_WE_IN(prwe), .IPL_WR_IN(iplwr), .IPL_WE_IN(iplwe), .NEST_DIS_IN(nest),
        .ALT_SEL_IN(alt), .LOW_PRIORITY_MASK_ACTIVE_START_IN(dstart), .LOW_PRIORITY_MASK_ACTIVE_COUNT_IN(dcnt), .ACK_IN(ack),
        .RETURN_IN(ret), .RESTORE_SRL_IN(rsrl), .RESTORE_IPL3_IN(1'b0), .TRAP_IN(ctl[3:0]),
        .TRAP_DONE_IN(tdone), .FETCH_ADDR_IN(ad), .FETCH_IN(ctl[10]), .VECTOR_FETCH_IN(ctl[9]),
        .JUMP_IN(ctl[8]), .JUMP_ADDR_IN(ad), .UNINIT_PTR_IN(ctl[7]), .ILLEGAL_EXEC_IN(ctl[6]),
        .FLUSH_IN(ctl[5]), .WDT_TIMEOUT_IN(ctl[4]), .FLAGS_OUT(flags), .ENABLES_OUT(enables),
        .PRIOS_OUT(prios), .IPL_OUT(cpu_priority_level), .LOW_PRIORITY_MASK_ACTIVE_ACTIVE_OUT(low_priority_mask_active), .IRQ_OUT(irq),
        .VECTOR_OUT(vec), .VEC_ADDR_OUT(vaddr), .PUSH_SRL_OUT(psrl), .ADDR_ERR_OUT(aerr),
        .DEV_RESET_OUT(dres));
    // ****
    // shared tasks
    // ****
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic src(int s, logic e, logic [2:0] p);
        en[s] = e;
        pr[s*4 +: 4] = {1'b0, p};
        {enwe, prwe} = 2'h3;
        step(1);
        {enwe, prwe} = 2'h0;
        // idle edge so a following call never re-raises the strobe in the same step
        step(1);
    endtask : src
    task automatic fire(logic [53:0] m);
        ev = m;
        step(1);
        ev = '0;
    endtask : fire
    task automatic ipl_wr(logic [3:0] v);
        iplwr = v;
        iplwe = 1'b1;
        step(1);
        iplwe = 1'b0;
    endtask : ipl_wr
    // waits for a request, checks it, lets the core acknowledge it
    task automatic take(int v, logic [23:0] base, logic [3:0] lvl);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 40)
        begin
            step(1);
            k++;
        end
        chk("vector", vec, v);
        chk("pushed level", psrl, {5'h00, cpu_priority_level[2:0]});
        chk("vec addr", vaddr, base + 24'(2 * v));
        while (irq === 1'b1 && k < 80)
        begin
            step(1);
            k++;
        end
        chk("level", cpu_priority_level, lvl);
    endtask : take
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // ****
    // scenarios
    // ****
    task automatic t_basic();
        fire(54'h8);
        chk("flag set", flags[3], 1'b1);
        step(6);
        chk("disabled src", irq, 1'b0);
        fire(54'h4000_0000);
        chk("reserved flag", flags[30], 1'b0);
        tclr[3] = 1'b1;
        step(1);
        tclr = '0;
        chk("flag clear", flags[3], 1'b0);
        src(7, 1'b1, 3'h0);
        fire(54'h80);
        step(8);
        chk("prio zero", irq, 1'b0);
    endtask : t_basic
    task automatic t_order();
        ackw = 4'h5;
        src(5, 1'b1, 3'h3);
        src(2, 1'b1, 3'h3);
        fire(54'h24);
        take(10, IB, 4'h3);
        take(13, IB, 4'h3);
        src(9, 1'b1, 3'h5);
        src(4, 1'b1, 3'h2);
        fire(54'h210);
        take(17, IB, 4'h5);
        take(12, IB, 4'h2);
        step(14);
        chk("level back", cpu_priority_level, 4'h0);
        ackw = 4'h0;
    endtask : t_order
    task automatic t_ipl();
        ipl_wr(4'h4);
        chk("level write", cpu_priority_level, 4'h4);
        src(11, 1'b1, 3'h4);
        fire(54'h800);
        step(8);
        chk("equal level", irq, 1'b0);
        src(11, 1'b1, 3'h5);
        take(19, IB, 4'h5);
        step(14);
        chk("level restore", cpu_priority_level, 4'h4);
        ipl_wr(4'h0);
        alt = 1'b1;
        src(0, 1'b1, 3'h1);
        fire(54'h1);
        take(8, intc_pkg::ALTERNATE_VECTOR_TABLE_BASE, 4'h1);
        step(14);
        alt = 1'b0;
    endtask : t_ipl
    task automatic t_nest();
        nest = 1'b1;
        ipl_wr(4'h6);
        chk("level locked", cpu_priority_level, 4'h0);
        src(1, 1'b1, 3'h2);
        src(6, 1'b1, 3'h7);
        fire(54'h2);
        take(9, IB, 4'h2);
        fire(54'h40);
        step(8);
        chk("no nesting", irq, 1'b0);
        take(14, IB, 4'h7);
        step(14);
        nest = 1'b0;
    endtask : t_nest
    task automatic t_low_priority_mask_active();
        src(12, 1'b1, 3'h6);
        src(13, 1'b1, 3'h7);
        dcnt = 14'h0008;
        dstart = 1'b1;
        step(1);
        dstart = 1'b0;
        chk("mask status", low_priority_mask_active, 1'b1);
        fire(54'h1000);
        step(8);
        chk("masked six", irq, 1'b0);
        fire(54'h2000);
        take(21, IB, 4'h7);
        take(20, IB, 4'h6);
        step(14);
    endtask : t_low_priority_mask_active
    task automatic t_err();
        for (int k = 0; k < 12; k++)
        begin
            ctl = ct[k];
            ad = ca[k];
            step(1);
            chk("addr err", aerr, ce[k][1]);
            chk("dev reset", dres, ce[k][0]);
        end
        ctl = '0;
        chk("trap level", cpu_priority_level[3], 1'b1);
        tdone = 1'b1;
        step(1);
        tdone = 1'b0;
        chk("trap done", cpu_priority_level[3], 1'b0);
    endtask : t_err
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        step(10);
        rst = 1'b0;
        chk("prio reset", prios[3:0], 4'h4);
        chk("reserved prio", prios[30*4 +: 4], 4'h0);
        chk("ipl reset", cpu_priority_level, 4'h0);
        t_basic();
        t_order();
        t_ipl();
        t_nest();
        t_low_priority_mask_active();
        t_err();
        end_sim();
    end
endmodule : tb
